// ### core/utrbf_rx_fifo.v
// receive buffer memory with registered head output
`timescale 1ns/1ps
`default_nettype none
module utrbf_rx_fifo #(
  parameter W = 12,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire flush,
  input wire push,
  input wire [W-1:0] push_data,
  input wire pop,
  // status and head
  output wire full,
  output reg rd_valid,
  output reg [W-1:0] rd_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire do_push = push & ~full;
  wire do_pop = pop & (count_r != {(AW+1){1'b0}});
  assign full = (count_r == DEPTH[AW:0]);

  function [AW-1:0] inc;
    input [AW-1:0] p;
    begin
      inc = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  always @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr_r] <= push_data;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      rd_valid <= 1'b0;
      rd_data <= {W{1'b0}};
    end
    else
    begin
      rd_valid <= (count_r != {(AW+1){1'b0}});
      rd_data <= (count_r != {(AW+1){1'b0}}) ? mem[rd_ptr_r] : {W{1'b0}};
      if (flush)
      begin
        wr_ptr_r <= {AW{1'b0}};
        rd_ptr_r <= {AW{1'b0}};
        count_r <= {(AW+1){1'b0}};
      end
      else
      begin
        if (do_push)
          wr_ptr_r <= inc(wr_ptr_r);
        if (do_pop)
          rd_ptr_r <= inc(rd_ptr_r);
        if (do_push & ~do_pop)
          count_r <= count_r + 1'b1;
        else if (do_pop & ~do_push)
          count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### core/utrbf_top.v
// serial transceiver: AHB-Lite registers, transmitter, receiver and buffer
`timescale 1ns/1ps
`default_nettype none
`include "utrbf_defs.vh"
module utrbf_top #(
  parameter FIFO_DEPTH = 2,
  parameter FIFO_AW = 1
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // serial pins
  input wire rxd_in,
  input wire xck_in,
  output reg txd_out,
  output reg txd_oe,
  output reg rxd_override,
  // interrupt requests
  input wire tx_complete_ack,
  output reg buffer_empty_irq,
  output reg tx_complete_irq
);
  localparam TX_IDLE = 3'd0;
  localparam TX_START = 3'd1;
  localparam TX_DATA = 3'd2;
  localparam TX_PAR = 3'd3;
  localparam TX_STOP1 = 3'd4;
  localparam TX_STOP2 = 3'd5;
  localparam RX_IDLE = 3'd0;
  localparam RX_START = 3'd1;
  localparam RX_DATA = 3'd2;
  localparam RX_PAR = 3'd3;
  localparam RX_STOP = 3'd4;

  function [3:0] data_bits;
    input [2:0] c;
    begin
      if (c == `UTRBF_SZ9)
        data_bits = 4'd9;
      else if (c[2])
        data_bits = 4'd8;
      else
        data_bits = 4'd5 + {2'b00, c[1:0]};
    end
  endfunction

  function parity_of;
    input [8:0] d;
    input [3:0] n;
    input odd;
    integer i;
    begin
      parity_of = odd;
      for (i = 0; i < 9; i = i + 1)
        if (i < n)
          parity_of = parity_of ^ d[i];
    end
  endfunction

  // configuration
  reg [7:0] csr_b_r;
  reg [7:0] csr_c_r;
  reg [11:0] baud_r;
  reg [11:0] baud_cnt_r;
  wire [2:0] size_code = {csr_b_r[`UTRBF_B_SZ2], csr_c_r[`UTRBF_C_SZ1], csr_c_r[`UTRBF_C_SZ0]};
  wire [3:0] nbits = data_bits(size_code);
  wire sync_mode = csr_c_r[`UTRBF_C_SYNC];
  wire par_en = csr_c_r[`UTRBF_C_PM1];
  wire par_odd = csr_c_r[`UTRBF_C_PM0];
  wire two_stop = csr_c_r[`UTRBF_C_SBS];
  wire rx_on = csr_b_r[`UTRBF_B_RXEN];
  wire tick = (baud_cnt_r == 12'h000);

  // pin synchronisers
  reg [1:0] rxd_s_r;
  reg [1:0] xck_s_r;
  reg xck_d_r;
  wire rxd = rxd_s_r[1];
  wire xck_rise = xck_s_r[1] & ~xck_d_r;
  wire xck_fall = ~xck_s_r[1] & xck_d_r;

  // bus data phase
  reg dph_r;
  reg dwr_r;
  reg dok_r;
  reg [7:0] dadr_r;
  wire acc = hsel & htrans[1] & hready;
  wire wr_stb = dph_r & dwr_r & dok_r;
  wire rd_stb = dph_r & ~dwr_r;

  // transmitter state
  reg [8:0] thr_r;
  reg thr_full_r;
  reg txen_eff_r;
  reg [2:0] tx_st_r;
  reg [8:0] tsr_r;
  reg [3:0] tx_n_r;
  reg [3:0] tx_sub_r;
  reg tx_par_r;
  reg txc_r;
  wire tx_adv = sync_mode ? xck_fall : (tick & (tx_sub_r == `UTRBF_OSR_LAST));
  wire tx_last_end = tx_adv & (((tx_st_r == TX_STOP1) & ~two_stop) | (tx_st_r == TX_STOP2));
  wire tx_load = txen_eff_r & thr_full_r & ((tx_st_r == TX_IDLE) | tx_last_end);
  wire data_wr = wr_stb & (dadr_r == `UTRBF_OFF_DATA);
  wire txc_w1c = wr_stb & (dadr_r == `UTRBF_OFF_CSRA) & hwdata[`UTRBF_A_TXC];

  // receiver state
  reg [2:0] rx_st_r;
  reg [3:0] rx_sub_r;
  reg [3:0] rx_n_r;
  reg [8:0] rsr_r;
  reg rx_parbit_r;
  reg rsr_full_r;
  reg [`UTRBF_ENTRY_W-2:0] rsr_ent_r;
  reg dor_pend_r;
  wire fifo_full;
  wire head_valid;
  wire [`UTRBF_ENTRY_W-1:0] head;
  wire rx_samp = sync_mode ? xck_rise : (tick & (rx_sub_r == `UTRBF_OSR_LAST));
  wire start_ok = sync_mode ? ((rx_st_r == RX_IDLE) & xck_rise & ~rxd)
    : ((rx_st_r == RX_START) & tick & (rx_sub_r == `UTRBF_START_MID) & ~rxd);
  wire overrun = rx_on & start_ok & fifo_full & rsr_full_r;
  wire [8:0] aligned = rsr_r >> (4'd9 - nbits);
  wire fifo_push = rsr_full_r & ~fifo_full;
  wire fifo_pop = rd_stb & (dadr_r == `UTRBF_OFF_DATA) & head_valid;

  // read mux
  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (dadr_r)
      `UTRBF_OFF_DATA: rd_mux = {24'h000000, head[7:0]};
      `UTRBF_OFF_CSRA:
      begin
        rd_mux[`UTRBF_A_RXC] = head_valid;
        rd_mux[`UTRBF_A_TXC] = txc_r;
        rd_mux[`UTRBF_A_UDRE] = ~thr_full_r;
        rd_mux[`UTRBF_A_FE] = head[`UTRBF_E_FE];
        rd_mux[`UTRBF_A_DOR] = head[`UTRBF_E_DOR];
        rd_mux[`UTRBF_A_PE] = head[`UTRBF_E_PE];
      end
      `UTRBF_OFF_CSRB:
      begin
        rd_mux[7:0] = csr_b_r;
        rd_mux[`UTRBF_B_RXB8] = head[`UTRBF_E_B8];
      end
      `UTRBF_OFF_CSRC: rd_mux[7:0] = csr_c_r;
      `UTRBF_OFF_BAUD: rd_mux[11:0] = baud_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // bus slave, one wait state per transfer
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_r <= 1'b0;
      dwr_r <= 1'b0;
      dok_r <= 1'b0;
      dadr_r <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end
    else if (acc)
    begin
      dph_r <= 1'b1;
      dwr_r <= hwrite;
      dok_r <= (hsize == 3'h2);
      dadr_r <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
      hreadyout <= 1'b0;
    end
    else if (dph_r)
    begin
      dph_r <= 1'b0;
      hreadyout <= 1'b1;
      if (rd_stb)
        hrdata <= rd_mux;
    end
  end

  // configuration registers
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      csr_b_r <= `UTRBF_B_RST;
      csr_c_r <= `UTRBF_C_RST;
      baud_r <= `UTRBF_BAUD_RST;
      baud_cnt_r <= `UTRBF_BAUD_RST;
    end
    else
    begin
      baud_cnt_r <= tick ? baud_r : baud_cnt_r - 12'h001;
      if (wr_stb & (dadr_r == `UTRBF_OFF_CSRB))
        csr_b_r <= {hwdata[7:2], 1'b0, hwdata[0]};
      if (wr_stb & (dadr_r == `UTRBF_OFF_CSRC))
        csr_c_r <= {1'b0, hwdata[6:0]};
      if (wr_stb & (dadr_r == `UTRBF_OFF_BAUD))
        baud_r <= hwdata[11:0];
    end
  end

  // synchronisers, pin overrides, requests
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rxd_s_r <= 2'b11;
      xck_s_r <= 2'b00;
      xck_d_r <= 1'b0;
      txd_oe <= 1'b0;
      rxd_override <= 1'b0;
      buffer_empty_irq <= 1'b0;
      tx_complete_irq <= 1'b0;
    end
    else
    begin
      rxd_s_r <= {rxd_s_r[0], rxd_in};
      xck_s_r <= {xck_s_r[0], xck_in};
      xck_d_r <= xck_s_r[1];
      txd_oe <= txen_eff_r;
      rxd_override <= rx_on;
      buffer_empty_irq <= csr_b_r[`UTRBF_B_UDRIE] & ~thr_full_r;
      tx_complete_irq <= csr_b_r[`UTRBF_B_TXCIE] & txc_r;
    end
  end

  // transmitter
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      thr_r <= 9'h000;
      thr_full_r <= 1'b0;
      txen_eff_r <= 1'b0;
      tx_st_r <= TX_IDLE;
      tsr_r <= 9'h000;
      tx_n_r <= 4'h0;
      tx_sub_r <= 4'h0;
      tx_par_r <= 1'b0;
      txc_r <= 1'b0;
      txd_out <= 1'b1;
    end
    else
    begin
      if (csr_b_r[`UTRBF_B_TXEN])
        txen_eff_r <= 1'b1;
      else if (~thr_full_r & (tx_st_r == TX_IDLE))
        txen_eff_r <= 1'b0;
      if (tx_last_end & ~tx_load)
        txc_r <= 1'b1;
      else if (txc_w1c | tx_complete_ack)
        txc_r <= 1'b0;
      if ((tx_st_r != TX_IDLE) & tick)
        tx_sub_r <= tx_sub_r + 4'h1;
      if (data_wr)
      begin
        thr_r <= {csr_b_r[`UTRBF_B_TXB8], hwdata[7:0]};
        thr_full_r <= 1'b1;
      end
      else if (tx_load)
        thr_full_r <= 1'b0;
      if (tx_load)
      begin
        tsr_r <= thr_r;
        tx_par_r <= parity_of(thr_r, nbits, par_odd);
        tx_st_r <= TX_START;
        tx_sub_r <= 4'h0;
        txd_out <= 1'b0;
      end
      else if (tx_adv)
      begin
        case (tx_st_r)
          TX_START:
          begin
            txd_out <= tsr_r[0];
            tsr_r <= tsr_r >> 1;
            tx_n_r <= 4'h1;
            tx_st_r <= TX_DATA;
          end
          TX_DATA:
          begin
            if (tx_n_r == nbits)
            begin
              txd_out <= par_en ? tx_par_r : 1'b1;
              tx_st_r <= par_en ? TX_PAR : TX_STOP1;
            end
            else
            begin
              txd_out <= tsr_r[0];
              tsr_r <= tsr_r >> 1;
              tx_n_r <= tx_n_r + 4'h1;
            end
          end
          TX_PAR:
          begin
            txd_out <= 1'b1;
            tx_st_r <= TX_STOP1;
          end
          TX_STOP1:
          begin
            tx_st_r <= two_stop ? TX_STOP2 : TX_IDLE;
          end
          TX_STOP2: tx_st_r <= TX_IDLE;
          default:
          begin
            tx_st_r <= TX_IDLE;
            txd_out <= 1'b1;
          end
        endcase
      end
    end
  end

  // receiver
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_st_r <= RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_n_r <= 4'h0;
      rsr_r <= 9'h000;
      rx_parbit_r <= 1'b0;
      rsr_full_r <= 1'b0;
      rsr_ent_r <= 11'h000;
      dor_pend_r <= 1'b0;
    end
    else if (~rx_on)
    begin
      rx_st_r <= RX_IDLE;
      rsr_full_r <= 1'b0;
      dor_pend_r <= 1'b0;
    end
    else
    begin
      if (overrun)
        dor_pend_r <= 1'b1;
      else if (fifo_push)
        dor_pend_r <= 1'b0;
      if (tick)
        rx_sub_r <= rx_sub_r + 4'h1;
      if (start_ok)
      begin
        rx_st_r <= RX_DATA;
        rx_sub_r <= 4'h0;
        rx_n_r <= 4'h0;
      end
      else
      begin
        case (rx_st_r)
          RX_IDLE:
          begin
            if (~sync_mode & ~rxd)
            begin
              rx_st_r <= RX_START;
              rx_sub_r <= 4'h0;
            end
          end
          RX_START:
          begin
            if (tick & (rx_sub_r == `UTRBF_START_MID))
              rx_st_r <= RX_IDLE;
          end
          RX_DATA:
          begin
            if (rx_samp)
            begin
              rsr_r <= {rxd, rsr_r[8:1]};
              rx_n_r <= rx_n_r + 4'h1;
              if (rx_n_r == nbits - 4'h1)
                rx_st_r <= par_en ? RX_PAR : RX_STOP;
            end
          end
          RX_PAR:
          begin
            if (rx_samp)
            begin
              rx_parbit_r <= rxd;
              rx_st_r <= RX_STOP;
            end
          end
          RX_STOP:
          begin
            if (rx_samp)
            begin
              rx_st_r <= RX_IDLE;
              if (~rsr_full_r | fifo_push)
              begin
                rsr_full_r <= 1'b1;
                rsr_ent_r <= {par_en & (rx_parbit_r != parity_of(aligned, nbits, par_odd)),
                  ~rxd, (nbits == 4'd9) & aligned[8], aligned[7:0]};
              end
            end
          end
          default: rx_st_r <= RX_IDLE;
        endcase
      end
      if (fifo_push & ~((rx_st_r == RX_STOP) & rx_samp & ~start_ok))
        rsr_full_r <= 1'b0;
    end
  end

  utrbf_rx_fifo #(
    .W(`UTRBF_ENTRY_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_rx_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .flush(~rx_on),
    .push(fifo_push),
    .push_data({rsr_ent_r[10], dor_pend_r, rsr_ent_r[9:0]}),
    .pop(fifo_pop),
    .full(fifo_full),
    .rd_valid(head_valid),
    .rd_data(head)
  );
endmodule
`default_nettype wire

// ### shared/utrbf_defs.vh
// register map, field positions and constants of the serial transceiver
// Functional notes
// - buffer-empty flag high exactly while holding buffer empty
// - data write loads buffer, clears buffer-empty flag
// - buffer-empty request is a level while enabled
// - complete flag sets when frame out, buffer empty
// - complete flag clears on service or write-one
// - complete request raised when enabled flag sets
// - parity bit after last data bit when enabled
// - transmitter disable waits until nothing left to send
// - disabled transmitter releases transmit pin override
// - receiver enable overrides receive pin function
// - synchronous receiver clocks on external transfer clock
// - valid start bit, then sample bits into shifter
// - second stop bit ignored by receiver
// - first stop bit moves frame into receive buffer
// - unused upper data bits read as zero
// - ninth bit and errors stored per entry
// - shifter loads when idle or after last stop
// - receive-complete flag shows unread buffered data
// - two-entry buffer; overrun on fourth start bit
`ifndef UTRBF_DEFS_VH
`define UTRBF_DEFS_VH
`define UTRBF_OFF_DATA 8'h00
`define UTRBF_OFF_CSRA 8'h04
`define UTRBF_OFF_CSRB 8'h08
`define UTRBF_OFF_CSRC 8'h0C
`define UTRBF_OFF_BAUD 8'h10
`define UTRBF_A_RXC 7
`define UTRBF_A_TXC 6
`define UTRBF_A_UDRE 5
`define UTRBF_A_FE 4
`define UTRBF_A_DOR 3
`define UTRBF_A_PE 2
`define UTRBF_B_TXCIE 6
`define UTRBF_B_UDRIE 5
`define UTRBF_B_RXEN 4
`define UTRBF_B_TXEN 3
`define UTRBF_B_SZ2 2
`define UTRBF_B_RXB8 1
`define UTRBF_B_TXB8 0
`define UTRBF_C_SYNC 6
`define UTRBF_C_PM1 5
`define UTRBF_C_PM0 4
`define UTRBF_C_SBS 3
`define UTRBF_C_SZ1 2
`define UTRBF_C_SZ0 1
`define UTRBF_B_RST 8'h00
`define UTRBF_C_RST 8'h06
`define UTRBF_BAUD_RST 12'h000
`define UTRBF_SZ9 3'h7
`define UTRBF_OSR_LAST 4'hF
`define UTRBF_START_MID 4'h7
`define UTRBF_ENTRY_W 12
`define UTRBF_E_B8 8
`define UTRBF_E_FE 9
`define UTRBF_E_DOR 10
`define UTRBF_E_PE 11
`endif

// ### test/uart_tx_rx_buffer_flags_tb_top.sv
// register-level testbench of the serial transceiver
`timescale 1ns/1ps
`default_nettype none
`include "utrbf_defs.vh"
module uart_tx_rx_buffer_flags_tb_top;
  localparam logic [7:0] off_d = `UTRBF_OFF_DATA;
  localparam logic [7:0] off_a = `UTRBF_OFF_CSRA;
  localparam logic [7:0] off_b = `UTRBF_OFF_CSRB;
  localparam logic [7:0] off_c = `UTRBF_OFF_CSRC;
  localparam logic [7:0] off_r = `UTRBF_OFF_BAUD;
  localparam logic [31:0] all_m = 32'hFFFFFFFF;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic tx_complete_ack = 1'h0;
  wire hreadyout, hresp, txd_out, txd_oe, rxd_override, buffer_empty_irq, tx_complete_irq, rxd, external_transfer_clock_pin;
  wire [31:0] hrdata;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  always #20 hclk = ~hclk;
  utrbf_top #(.FIFO_DEPTH(2), .FIFO_AW(1)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rxd_in(rxd), .xck_in(external_transfer_clock_pin), .txd_out(txd_out),
    .txd_oe(txd_oe), .rxd_override(rxd_override), .tx_complete_ack(tx_complete_ack),
    .buffer_empty_irq(buffer_empty_irq), .tx_complete_irq(tx_complete_irq));
  utrbf_remote remote (.hclk(hclk), .txd(txd_out), .rxd(rxd), .external_transfer_clock_pin(external_transfer_clock_pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // holds everything until the rising edge after hready is seen high at a falling edge
  task automatic wait_rdy(output logic [31:0] q);
    logic ok;
    do
    begin
      @(negedge hclk);
      ok = hreadyout;
      q = hrdata;
      @(posedge hclk);
    end while (ok !== 1'h1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wait_rdy(q);
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy(q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wait_tx(input int n);
    while (remote.count < n) @(posedge hclk);
    gap(10);
  endtask
  task results;
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      $display("CHECK FAILED %0t timeout", $time);
      results;
    end
  end
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(off_a, all_m, 32'h20);
    rd(off_b, all_m, 32'h0);
    rd(8'hFC, all_m, 32'h0);
    wr(off_b, 32'h68);
    gap(3);
    chk(buffer_empty_irq, 32'h1);
    wr(off_d, 32'hA5);
    wr(off_d, 32'h3C);
    rd(off_a, 32'h60, 32'h0);
    chk(buffer_empty_irq, 32'h0);
    wr(off_a, 32'h0);
    wait_tx(2);
    chk(remote.seen[0], 32'h1A5);
    chk(remote.seen[1], 32'h13C);
    gap(10);
    rd(off_a, 32'h60, 32'h60);
    chk(tx_complete_irq, 32'h1);
    wr(off_a, 32'h40);
    rd(off_a, 32'h40, 32'h0);
    wr(off_d, 32'h81);
    wait_tx(3);
    chk(remote.seen[2], 32'h181);
    gap(10);
    tx_complete_ack <= 1'h1;
    @(posedge hclk);
    tx_complete_ack <= 1'h0;
    gap(3);
    chk(tx_complete_irq, 32'h0);
    wr(off_b, 32'h08);
    gap(3);
    chk(buffer_empty_irq, 32'h0);
    remote.nbits = 10;
    wr(off_c, 32'h26);
    wr(off_d, 32'h07);
    wait_tx(4);
    chk(remote.seen[3], 32'h307);
    wr(off_c, 32'h36);
    wr(off_d, 32'h07);
    wait_tx(5);
    chk(remote.seen[4], 32'h207);
    wr(off_c, 32'h06);
    wr(off_b, 32'h0D);
    wr(off_d, 32'h5A);
    wr(off_b, 32'h04);
    wait_tx(6);
    chk(remote.seen[5], 32'h35A);
    gap(8);
    chk(txd_oe, 32'h0);
    wr(off_c, 32'h0E);
    wr(off_b, 32'h14);
    gap(3);
    chk(rxd_override, 32'h1);
    remote.send(12'h3A5, 10);
    remote.send(12'h242, 10);
    gap(4);
    rd(off_b, 32'h02, 32'h02);
    rd(off_a, 32'h9C, 32'h80);
    rd(off_d, all_m, 32'hA5);
    gap(4);
    rd(off_b, 32'h02, 32'h0);
    rd(off_d, all_m, 32'h42);
    gap(4);
    rd(off_a, 32'h80, 32'h0);
    wr(off_b, 32'h10);
    remote.send(12'h111, 9);
    remote.send(12'h122, 9);
    remote.send(12'h133, 9);
    remote.send(12'h144, 9);
    gap(20);
    rd(off_a, 32'h9C, 32'h80);
    rd(off_d, all_m, 32'h11);
    rd(off_d, all_m, 32'h22);
    gap(6);
    rd(off_a, 32'h9C, 32'h88);
    rd(off_d, all_m, 32'h33);
    gap(6);
    rd(off_a, 32'h80, 32'h0);
    wr(off_c, 32'h08);
    remote.send(12'h035, 6);
    gap(6);
    rd(off_d, all_m, 32'h15);
    wr(off_c, 32'h46);
    remote.send_sync(12'h1C3, 9);
    gap(6);
    rd(off_d, all_m, 32'hC3);
    wr(off_c, 32'h0E);
    wr(off_b, 32'h08);
    wr(off_r, 32'h1);
    remote.nbits = 9;
    remote.bitlen = 32;
    wr(off_d, 32'h96);
    wait_tx(7);
    chk(remote.seen[6], 32'h196);
    results;
  end
endmodule
`default_nettype wire

// ### test/utrbf_properties.sv
// concurrent checks on the serial transceiver ports
`timescale 1ns/1ps
`default_nettype none
`include "utrbf_defs.vh"
module utrbf_properties (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  // serial pins and interrupt requests
  input wire txd_out,
  input wire txd_oe,
  input wire rxd_override,
  input wire tx_complete_ack,
  input wire buffer_empty_irq,
  input wire tx_complete_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reg ph_wr_r;
  reg [7:0] ph_addr_r;
  // data phase of a mapped word write
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_r <= 1'h0;
      ph_addr_r <= 8'h00;
    end
    else if (hsel && htrans[1] && hready)
    begin
      ph_wr_r <= hwrite && (hsize == 3'h2) && (haddr[31:8] == 24'h000000);
      ph_addr_r <= haddr[7:0];
    end
    else if (hreadyout)
      ph_wr_r <= 1'h0;
  end
  sequence s_taken; hsel && htrans[1] && hready; endsequence
  sequence s_wait; !hreadyout ##1 hreadyout; endsequence
  sequence s_wr_b; ph_wr_r && hreadyout && (ph_addr_r == `UTRBF_OFF_CSRB); endsequence
  a_ready_wait: assert property (s_taken |=> s_wait)
    else $error("wait state not exactly one cycle");
  a_bus_okay: assert property (!hresp)
    else $error("response not okay");
  a_be_irq_off: assert property (s_wr_b ##0 !hwdata[`UTRBF_B_UDRIE] |-> ##2 !buffer_empty_irq)
    else $error("buffer empty request after enable cleared");
  a_txc_irq_off: assert property (s_wr_b ##0 !hwdata[`UTRBF_B_TXCIE] |-> ##2 !tx_complete_irq)
    else $error("complete request after enable cleared");
  a_rx_override: assert property (s_wr_b |-> ##2 rxd_override == $past(hwdata[`UTRBF_B_RXEN], 2))
    else $error("receive pin override not following enable");
  a_ack_clear: assert property (tx_complete_ack |-> ##2 !tx_complete_irq)
    else $error("complete request survives service");
  a_low_owned: assert property (!txd_out |-> txd_oe)
    else $error("transmit line low without ownership");
  a_txc_after_stop: assert property ($rose(tx_complete_irq) |-> txd_out && $past(txd_out, 8))
    else $error("complete raised before stop bit");
endmodule
bind utrbf_top utrbf_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .txd_out(txd_out), .txd_oe(txd_oe), .rxd_override(rxd_override),
  .tx_complete_ack(tx_complete_ack), .buffer_empty_irq(buffer_empty_irq), .tx_complete_irq(tx_complete_irq));
`default_nettype wire

// ### test/utrbf_remote.sv
// remote serial transceiver: frame capture and frame sending, bitlen clocks a captured bit, 16 clocks a sent bit
`timescale 1ns/1ps
`default_nettype none
module utrbf_remote (
  // clock
  input wire logic hclk,
  // serial lines
  input wire logic txd,
  output var logic rxd,
  output var logic external_transfer_clock_pin
);
  int nbits = 9;
  int bitlen = 16;
  int count = 0;
  logic [11:0] seen [0:15];
  logic [11:0] got;
  initial rxd = 1'h1;
  // transfer clock stands low outside synchronous frames
  initial external_transfer_clock_pin = 1'h0;
  // mid-bit sampling, bit 0 first, stop bit included
  initial
  begin
    forever
    begin
      @(negedge txd);
      repeat (bitlen / 2) @(posedge hclk);
      if (txd === 1'h0)
      begin
        got = 12'h000;
        for (int i = 0; i < nbits; i++)
        begin
          repeat (bitlen) @(posedge hclk);
          got[i] = txd;
        end
        seen[count % 16] = got;
        count++;
      end
    end
  end
  // start bit, then n bits; the line is left at the value of the last one
  task automatic send(input logic [11:0] bits, input int n);
    rxd <= 1'h0;
    repeat (16) @(posedge hclk);
    for (int i = 0; i < n; i++)
    begin
      rxd <= bits[i];
      repeat (16) @(posedge hclk);
    end
  endtask
  // synchronous frame: line changes while the clock is low, sampled on its rise
  task automatic send_sync(input logic [11:0] bits, input int n);
    for (int i = 0; i <= n; i++)
    begin
      rxd <= (i == 0) ? 1'h0 : bits[i - 1];
      repeat (8) @(posedge hclk);
      external_transfer_clock_pin <= 1'h1;
      repeat (8) @(posedge hclk);
      external_transfer_clock_pin <= 1'h0;
    end
  endtask
endmodule
`default_nettype wire
